// >>> design/lusseq_top.sv
// Start-up qualification, brownout and X-capacitor monitor sequencer
`timescale 1ns/1ps
`default_nettype none
`include "lusseq_defs.svh"
module lusseq_top #(
    // All timings are overridable
    parameter int LW              = 10,
    parameter int PEAK_WINDOW_CYC = `LUS_PEAK_WINDOW_CYC,
    parameter int TEST_PERIOD_CYC = `LUS_TEST_PERIOD_CYC,
    parameter int RESET_SHORT_CYC = `LUS_RESET_SHORT_CYC,
    parameter int UV_DELAY_CYC    = `LUS_UV_DELAY_CYC,
    parameter int HV_ON_CYC       = `LUS_HV_ON_CYC,
    parameter int HV_SMP_CYC      = `LUS_HV_SMP_CYC,
    parameter int HV_WAIT_CYC     = `LUS_HV_WAIT_CYC
) (
    input  wire logic                   CORE_CLK,
    input  wire logic                   RESET,
    input  wire lusseq_pkg::lusseq_sense_s SENSE,
    input  wire logic [LW-1:0]          LINE_LEVEL,
    input  wire logic [LW-1:0]          LINE_TURN_ON_THRESHOLD,
    input  wire logic [LW-1:0]          LINE_TURN_OFF_THRESHOLD,
    input  wire logic                   LIGHT_LOAD,
    input  wire logic                   HV_AC_RIPPLE_OK,
    output logic                        HV_SOURCE_ON,
    output logic                        TEST_PULSE,
    output logic                        MIN_PEAK_DEMAND,
    output logic                        PWM_ENABLE,
    output logic                        LOW_POWER,
    output logic                        BIAS_DRAIN,
    output logic                        LATCHED_FAULT,
    output logic                        DC_FLAG,
    output logic                        XCAP_MONITOR_ON,
    output logic [LW-1:0]               LINE_PEAK
);
    localparam int TW = 32;

    lusseq_pkg::lusseq_state_e state;
    logic [TW-1:0] tmr;
    logic [1:0]    pulse_cnt;
    logic [TW-1:0] win_cnt;
    logic [LW-1:0] win_max;
    logic [TW-1:0] uv_cnt;
    logic          peak_valid;
    logic          uv_trip;
    logic          dc_event;
    logic          hv_sampling;
    logic [4:0]    hv_cnt;
    logic [TW-1:0] hv_tmr;
    logic          hv_in_wait;
    logic          hv_bad_seen;
    logic          mon_en;

    // ---------------------------------------------------------------
    // Main sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            state     <= lusseq_pkg::LUS_CHARGE;
            tmr       <= '0;
            pulse_cnt <= '0;
        end else begin
            case (state)
                lusseq_pkg::LUS_CHARGE: begin
                    tmr       <= '0;
                    pulse_cnt <= '0;
                    if (SENSE.bias_start_level) begin
                        state <= lusseq_pkg::LUS_TEST;
                    end
                end
                lusseq_pkg::LUS_TEST: begin
                    if (SENSE.output_overvoltage) begin
                        state <= lusseq_pkg::LUS_LATCHED;
                    end else if (tmr == TW'(TEST_PERIOD_CYC - 1)) begin
                        tmr <= '0;
                        if (pulse_cnt == 2'(`LUS_TEST_PULSES - 1)) begin
                            if (LINE_LEVEL > LINE_TURN_ON_THRESHOLD) begin
                                state <= lusseq_pkg::LUS_RUN;
                            end else begin
                                state <= lusseq_pkg::LUS_RESET_WAIT;
                            end
                        end else begin
                            pulse_cnt <= pulse_cnt + 2'd1;
                        end
                    end else begin
                        tmr <= tmr + TW'(1);
                    end
                end
                lusseq_pkg::LUS_RUN: begin
                    tmr <= '0;
                    if (uv_trip || dc_event) begin
                        state <= lusseq_pkg::LUS_RESET_WAIT;
                    end
                end
                lusseq_pkg::LUS_RESET_WAIT: begin
                    if (tmr == TW'(RESET_SHORT_CYC - 1)) begin
                        tmr   <= '0;
                        state <= lusseq_pkg::LUS_DRAIN;
                    end else begin
                        tmr <= tmr + TW'(1);
                    end
                end
                lusseq_pkg::LUS_DRAIN: begin
                    if (SENSE.bias_restart_level) begin
                        state <= lusseq_pkg::LUS_CHARGE;
                    end
                end
                lusseq_pkg::LUS_LATCHED: begin
                    tmr <= '0;
                    if (dc_event) begin
                        state <= lusseq_pkg::LUS_RESET_WAIT;
                    end
                end
                default: state <= lusseq_pkg::LUS_CHARGE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Line peak capture and brownout persistence
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            win_cnt   <= '0;
            win_max   <= '0;
            LINE_PEAK <= '0;
            peak_valid <= 1'b0;
        end else if (state != lusseq_pkg::LUS_RUN) begin
            win_cnt <= '0;
            win_max <= '0;
            peak_valid <= 1'b0;
        end else if (win_cnt == TW'(PEAK_WINDOW_CYC - 1)) begin
            win_cnt   <= '0;
            peak_valid <= 1'b1;
            LINE_PEAK <= (LINE_LEVEL > win_max) ? LINE_LEVEL : win_max;
            win_max   <= '0;
        end else begin
            win_cnt <= win_cnt + TW'(1);
            if (SENSE.line_sample_valid && LINE_LEVEL > win_max) begin
                win_max <= LINE_LEVEL;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            uv_cnt  <= '0;
            uv_trip <= 1'b0;
        // No brownout count until a full window has given a real peak
        end else if (state != lusseq_pkg::LUS_RUN || !peak_valid ||
                     LINE_PEAK >= LINE_TURN_OFF_THRESHOLD) begin
            uv_cnt  <= '0;
            uv_trip <= 1'b0;
        end else if (uv_cnt == TW'(UV_DELAY_CYC - 1)) begin
            uv_trip <= 1'b1;
        end else begin
            uv_cnt <= uv_cnt + TW'(1);
        end
    end

    // ---------------------------------------------------------------
    // X-capacitor monitor: burst sampling and DC detection
    // ---------------------------------------------------------------
    assign mon_en = (state == lusseq_pkg::LUS_LATCHED) ||
                    (state == lusseq_pkg::LUS_RUN && LIGHT_LOAD);

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            hv_tmr      <= '0;
            hv_cnt      <= '0;
            hv_in_wait  <= 1'b0;
            hv_sampling <= 1'b0;
            hv_bad_seen <= 1'b0;
            dc_event    <= 1'b0;
        end else if (!mon_en) begin
            hv_tmr      <= '0;
            hv_cnt      <= '0;
            hv_in_wait  <= 1'b0;
            hv_sampling <= 1'b0;
            hv_bad_seen <= 1'b0;
            dc_event    <= 1'b0;
        end else if (hv_in_wait) begin
            dc_event    <= 1'b0;
            hv_sampling <= 1'b0;
            if (hv_tmr == TW'(HV_WAIT_CYC - 1)) begin
                hv_tmr     <= '0;
                hv_in_wait <= 1'b0;
            end else begin
                hv_tmr <= hv_tmr + TW'(1);
            end
        end else begin
            dc_event    <= 1'b0;
            hv_sampling <= (hv_tmr < TW'(HV_ON_CYC));
            if (hv_tmr == TW'(HV_ON_CYC - 1) && !HV_AC_RIPPLE_OK) begin
                hv_bad_seen <= 1'b1;
            end
            if (hv_tmr == TW'(HV_SMP_CYC - 1)) begin
                hv_tmr <= '0;
                if (hv_cnt == 5'(`LUS_HV_BURST_LEN - 1)) begin
                    hv_cnt      <= '0;
                    hv_in_wait  <= 1'b1;
                    dc_event    <= hv_bad_seen;
                    hv_bad_seen <= 1'b0;
                end else begin
                    hv_cnt <= hv_cnt + 5'd1;
                end
            end else begin
                hv_tmr <= hv_tmr + TW'(1);
            end
        end
    end

    // ---------------------------------------------------------------
    // Registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            HV_SOURCE_ON    <= 1'b0;
            TEST_PULSE      <= 1'b0;
            MIN_PEAK_DEMAND <= 1'b0;
            PWM_ENABLE      <= 1'b0;
            LOW_POWER       <= 1'b0;
            BIAS_DRAIN      <= 1'b0;
            LATCHED_FAULT   <= 1'b0;
            DC_FLAG         <= 1'b0;
            XCAP_MONITOR_ON <= 1'b0;
        end else begin
            HV_SOURCE_ON    <= (state == lusseq_pkg::LUS_CHARGE &&
                                !SENSE.bias_start_level) ||
                               hv_sampling;
            TEST_PULSE      <= (state == lusseq_pkg::LUS_TEST) &&
                               !SENSE.output_overvoltage &&
                               (tmr == '0);
            MIN_PEAK_DEMAND <= (state == lusseq_pkg::LUS_TEST);
            PWM_ENABLE      <= (state == lusseq_pkg::LUS_RUN) &&
                               !uv_trip && !dc_event;
            LOW_POWER       <= (state == lusseq_pkg::LUS_RESET_WAIT);
            BIAS_DRAIN      <= (state == lusseq_pkg::LUS_DRAIN);
            LATCHED_FAULT   <= (state == lusseq_pkg::LUS_LATCHED);
            DC_FLAG         <= dc_event;
            XCAP_MONITOR_ON <= mon_en;
        end
    end
endmodule
`default_nettype wire

// >>> design/lusseq_defs.svh
// Timing and count constants for the line undervoltage start-up sequencer
`ifndef LUSSEQ_DEFS_SVH
`define LUSSEQ_DEFS_SVH
`define LUS_CLK_HZ          40000000
`define LUS_TEST_PULSES     3
`define LUS_HV_BURST_LEN    21
`define LUS_PEAK_WINDOW_US  11000
`define LUS_PEAK_WINDOW_CYC ((`LUS_CLK_HZ / 1000000) * `LUS_PEAK_WINDOW_US)
`define LUS_TEST_FREQ_HZ    1000
`define LUS_TEST_PERIOD_CYC (`LUS_CLK_HZ / `LUS_TEST_FREQ_HZ)
`define LUS_RESET_SHORT_US  1000
`define LUS_RESET_SHORT_CYC ((`LUS_CLK_HZ / 1000000) * `LUS_RESET_SHORT_US)
`define LUS_UV_DELAY_US     40000
`define LUS_UV_DELAY_CYC    ((`LUS_CLK_HZ / 1000000) * `LUS_UV_DELAY_US)
`define LUS_HV_ON_US        10
`define LUS_HV_ON_CYC       ((`LUS_CLK_HZ / 1000000) * `LUS_HV_ON_US)
`define LUS_HV_SMP_US       1000
`define LUS_HV_SMP_CYC      ((`LUS_CLK_HZ / 1000000) * `LUS_HV_SMP_US)
`define LUS_HV_WAIT_US      100000
`define LUS_HV_WAIT_CYC     ((`LUS_CLK_HZ / 1000000) * `LUS_HV_WAIT_US)
`endif

// >>> design/lusseq_pkg.sv
// Types for the line undervoltage start-up sequencer
package lusseq_pkg;
    typedef enum logic [2:0] {
        LUS_CHARGE,
        LUS_TEST,
        LUS_RUN,
        LUS_RESET_WAIT,
        LUS_DRAIN,
        LUS_LATCHED
    } lusseq_state_e;

    typedef struct packed {
        logic bias_start_level;
        logic bias_restart_level;
        logic output_overvoltage;
        logic line_sample_valid;
    } lusseq_sense_s;
endpackage

// >>> sim/lusseq_assertions.sv
// Port-level checks for the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module lusseq_assertions #(
    parameter int LW = 10
) (
    input wire logic                      CORE_CLK,
    input wire logic                      RESET,
    input wire lusseq_pkg::lusseq_sense_s SENSE,
    input wire logic [LW-1:0]             LINE_LEVEL,
    input wire logic [LW-1:0]             LINE_TURN_ON_THRESHOLD,
    input wire logic [LW-1:0]             LINE_TURN_OFF_THRESHOLD,
    input wire logic                      LIGHT_LOAD,
    input wire logic                      HV_AC_RIPPLE_OK,
    input wire logic                      HV_SOURCE_ON,
    input wire logic                      TEST_PULSE,
    input wire logic                      MIN_PEAK_DEMAND,
    input wire logic                      PWM_ENABLE,
    input wire logic                      LOW_POWER,
    input wire logic                      BIAS_DRAIN,
    input wire logic                      LATCHED_FAULT,
    input wire logic                      DC_FLAG,
    input wire logic                      XCAP_MONITOR_ON,
    input wire logic [LW-1:0]             LINE_PEAK
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    AST_PULSE_DEMAND: assert property (
        TEST_PULSE |-> MIN_PEAK_DEMAND && !HV_SOURCE_ON)
        else $error("test pulse without minimum demand");
    AST_PULSE_GAP: assert property (TEST_PULSE |=> !TEST_PULSE [*7])
        else $error("test pulses closer than one test period");
    AST_OVP_LATCH: assert property ($rose(LATCHED_FAULT) |->
        $past(SENSE.output_overvoltage) || $past(SENSE.output_overvoltage, 2))
        else $error("latched fault without output overvoltage");
    AST_PWM_EXCL: assert property (PWM_ENABLE |->
        !MIN_PEAK_DEMAND && !LOW_POWER && !BIAS_DRAIN)
        else $error("switching while testing or resting");
    AST_WAIT_DRAIN: assert property ($rose(LOW_POWER) |->
        LOW_POWER [*8] ##1 (BIAS_DRAIN && !LOW_POWER))
        else $error("reset wait length or drain wrong");
    AST_RESTART: assert property (BIAS_DRAIN && SENSE.bias_restart_level |->
        ##[1:3] (HV_SOURCE_ON && !BIAS_DRAIN))
        else $error("no restart after bias reached restart level");
    AST_DC_WAIT: assert property (DC_FLAG |=> !DC_FLAG ##[0:2] LOW_POWER)
        else $error("no reset wait after dc flag");
    AST_DC_GATE: assert property (DC_FLAG |->
        XCAP_MONITOR_ON || $past(XCAP_MONITOR_ON))
        else $error("dc flag with monitor off");
    AST_LATCH_XCAP: assert property (LATCHED_FAULT |-> XCAP_MONITOR_ON)
        else $error("monitor off in latched fault");
    AST_HEAVY_OFF: assert property (PWM_ENABLE && $past(PWM_ENABLE) &&
        !LIGHT_LOAD && !$past(LIGHT_LOAD) && !$past(LIGHT_LOAD, 2)
        |-> !XCAP_MONITOR_ON)
        else $error("monitor on above light load");
endmodule
bind lusseq_top lusseq_assertions #(.LW(LW)) lusseq_assertions_i (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .SENSE(SENSE),
    .LINE_LEVEL(LINE_LEVEL), .LINE_TURN_ON_THRESHOLD(LINE_TURN_ON_THRESHOLD),
    .LINE_TURN_OFF_THRESHOLD(LINE_TURN_OFF_THRESHOLD),
    .LIGHT_LOAD(LIGHT_LOAD), .HV_AC_RIPPLE_OK(HV_AC_RIPPLE_OK),
    .HV_SOURCE_ON(HV_SOURCE_ON), .TEST_PULSE(TEST_PULSE),
    .MIN_PEAK_DEMAND(MIN_PEAK_DEMAND), .PWM_ENABLE(PWM_ENABLE),
    .LOW_POWER(LOW_POWER), .BIAS_DRAIN(BIAS_DRAIN),
    .LATCHED_FAULT(LATCHED_FAULT), .DC_FLAG(DC_FLAG),
    .XCAP_MONITOR_ON(XCAP_MONITOR_ON), .LINE_PEAK(LINE_PEAK));
`default_nettype wire

// >>> sim/tb_lusseq_top.sv
// Self-checking testbench for the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_lusseq_top;
    localparam int HV = 0, TP = 1, MPD = 2, PWM = 3, LP = 4, DRN = 5;
    localparam int LAT = 6, DCF = 7, XC = 8, PK = 9;
    logic                      clk = 0;
    logic                      rst = 1;
    lusseq_pkg::lusseq_sense_s sense = 4'h1;
    logic [9:0]                lvl = 10'h000;
    logic [9:0]                on_th = 10'h200;
    logic [9:0]                off_th = 10'h100;
    logic                      light = 0;
    logic                      ripple = 1;
    logic [8:0]                outs;
    logic [9:0]                peak;
    int                        fail_count = 0;
    int                        n_compared = 0;
    int                        cyc = 0;
    always #12.5 clk = ~clk;
    lusseq_top #(.PEAK_WINDOW_CYC(32), .TEST_PERIOD_CYC(8), .RESET_SHORT_CYC(8),
        .UV_DELAY_CYC(16), .HV_ON_CYC(2), .HV_SMP_CYC(4), .HV_WAIT_CYC(8))
    lusseq_top_i (.CORE_CLK(clk), .RESET(rst), .SENSE(sense), .LINE_LEVEL(lvl),
        .LINE_TURN_ON_THRESHOLD(on_th), .LINE_TURN_OFF_THRESHOLD(off_th),
        .LIGHT_LOAD(light), .HV_AC_RIPPLE_OK(ripple),
        .HV_SOURCE_ON(outs[HV]), .TEST_PULSE(outs[TP]),
        .MIN_PEAK_DEMAND(outs[MPD]), .PWM_ENABLE(outs[PWM]),
        .LOW_POWER(outs[LP]), .BIAS_DRAIN(outs[DRN]),
        .LATCHED_FAULT(outs[LAT]), .DC_FLAG(outs[DCF]),
        .XCAP_MONITOR_ON(outs[XC]), .LINE_PEAK(peak));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    function automatic logic [9:0] pick(input int s);
        return s == PK ? peak : 10'(outs[s]);
    endfunction
    task automatic check(input string what, input logic [9:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic wait_out(input int s, input logic [9:0] v, input int lim);
        int n;
        n = 0;
        while (pick(s) !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        check($sformatf("output %0d", s), v, pick(s));
    endtask
    task automatic qualify(input logic [9:0] l, input logic ovp, output int p);
        lvl = l;
        sense.output_overvoltage = ovp;
        sense.bias_start_level = 1;
        wait_out(MPD, 1, 20);
        check("source in test", 0, pick(HV));
        sense.bias_start_level = 0;
        p = 0;
        while (outs[MPD] === 1'b1) begin
            p += (outs[TP] === 1'b1);
            @(negedge clk);
        end
        sense.output_overvoltage = 0;
    endtask
    task automatic restart();
        wait_out(DRN, 1, 20);
        sense.bias_restart_level = 1;
        wait_out(HV, 1, 4);
        sense.bias_restart_level = 0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_low_line();
        int p, n;
        qualify(10'h100, 0, p);
        check("test pulses", 3, 10'(p));
        wait_out(LP, 1, 3);
        n = 0;
        while (outs[LP] === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("reset wait", 8, 10'(n));
        restart();
    endtask
    task automatic sc_run_peak();
        int p;
        qualify(10'h300, 0, p);
        check("test pulses", 3, 10'(p));
        wait_out(PWM, 1, 3);
        check("monitor full load", 0, pick(XC));
        lvl = 10'h3f0;
        @(negedge clk);
        lvl = 10'h300;
        wait_out(PK, 10'h3f0, 80);
        wait_out(PK, 10'h300, 80);
    endtask
    task automatic sc_dc_run();
        light = 1;
        wait_out(XC, 1, 4);
        ripple = 0;
        wait_out(DCF, 1, 300);
        wait_out(LP, 1, 3);
        light = 0;
        ripple = 1;
        restart();
    endtask
    task automatic sc_brownout();
        int p;
        qualify(10'h300, 0, p);
        wait_out(PWM, 1, 3);
        lvl = 10'h050;
        repeat (10) @(negedge clk);
        check("run before delay", 1, pick(PWM));
        wait_out(LP, 1, 120);
        check("pwm halted", 0, pick(PWM));
        restart();
    endtask
    task automatic sc_ovp();
        int p;
        qualify(10'h300, 1, p);
        check("pulses after overvoltage", 1, 10'(p <= 1));
        wait_out(LAT, 1, 3);
        check("monitor in fault", 1, pick(XC));
        ripple = 0;
        wait_out(DCF, 1, 300);
        wait_out(LP, 1, 3);
        check("fault cleared", 0, pick(LAT));
        ripple = 1;
        restart();
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        check("outputs in reset", 0, {1'b0, outs});
        rst = 0;
        wait_out(HV, 1, 4);
        sc_low_line();
        sc_run_peak();
        sc_dc_run();
        sc_brownout();
        sc_ovp();
        tally_and_finish();
    end
endmodule
`default_nettype wire
